// [core/afc_chain.sv]
/*
 * Accelerometer filter chain top: register port, sample-rate divider,
 * three axis filters, path selection, reference mode and output FIFO.
 * Assumes converter samples are synchronous to ref_clk_i and are
 * valid whenever the chain takes one.
 */
`timescale 1ns/1ns
module afc_chain
    import afc_pkg::*;
#(
    parameter int BASE_DIV_P = afc_pkg::BASE_DIV,
    parameter int FIFO_DEPTH_P = afc_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [afc_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [afc_pkg::DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [afc_pkg::DW-1:0] reg_rdata_o,
    input wire afc_pkg::afc_xyz_t adc_sample_i,
    output logic adc_take_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output afc_pkg::afc_xyz_t out_data_o,
    output afc_pkg::afc_xyz_t slope_o,
    output afc_pkg::afc_xyz_t orient_o
);
    import afc_pkg::*;

    // ************************************************************
    // Register port
    // ************************************************************
    logic [DW-1:0] ctrl1_r;
    logic [DW-1:0] filt_r;
    logic [SETTLE_W-1:0] settle_r;
    logic ref_held_r;
    afc_state_t state_r;
    afc_xyz_t last_r;

    wire wr_ctrl1 = reg_wr_i && reg_addr_i == ADDR_CTRL1;
    wire wr_filt = reg_wr_i && reg_addr_i == ADDR_FILT;
    wire [3:0] rate = ctrl1_r[RATE_LSB +: 4];
    wire lp2_en = ctrl1_r[LP2_EN_BIT];
    wire [2:0] code = filt_r[CUT_LSB +: 3];
    wire path = filt_r[PATH_BIT];
    wire fast = filt_r[FAST_BIT];
    wire orient_sel = filt_r[ORIENT_BIT];
    wire ref_cfg = filt_r[REF_BIT] && path && code != CUT_SLOPE;

    wire [DW-1:0] status = {settle_r, 1'b0, settle_r != '0,
        ref_held_r, state_r};
    wire [DW-1:0] rd_mux =
        reg_addr_i == ADDR_CTRL1 ? ctrl1_r :
        reg_addr_i == ADDR_FILT ? filt_r :
        reg_addr_i == ADDR_STATUS ? status :
        reg_addr_i == ADDR_OUT_X ? last_r.x :
        reg_addr_i == ADDR_OUT_Y ? last_r.y :
        reg_addr_i == ADDR_OUT_Z ? last_r.z : 16'h0000;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl1_r <= CTRL1_RST;
            filt_r <= FILT_RST;
            reg_rdata_o <= 16'h0000;
        end else begin
            if (wr_ctrl1) ctrl1_r <= reg_wdata_i & CTRL1_MASK;
            if (wr_filt) filt_r <= reg_wdata_i & FILT_MASK;
            reg_rdata_o <= reg_rd_i ? rd_mux : 16'h0000;
        end
    end

    // ************************************************************
    // Power state and sample-rate divider
    // ************************************************************
    // Codes above the top rate run at the top rate
    wire [3:0] rate_c = (rate > RATE_MAX) ? RATE_MAX : rate;
    wire [DIV_W-1:0] period = DIV_W'(BASE_DIV_P) << (RATE_MAX - rate_c);
    wire pd_req = rate == RATE_PD;
    logic [DIV_W-1:0] div_r;
    logic pend_r;
    logic push_r;
    logic fifo_ready;
    wire tick = !pd_req && div_r == period - 1'b1;
    // A full FIFO holds the pending sample back instead of losing it
    wire step = pend_r && fifo_ready && state_r != ST_PD;
    afc_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_PD: begin
                if (!pd_req) state_nxt = fast ? ST_SEED : ST_RUN;
            end
            ST_SEED: begin
                if (pd_req) state_nxt = ST_PD;
                else if (step) state_nxt = ST_RUN;
            end
            ST_RUN: begin
                if (pd_req) state_nxt = ST_PD;
            end
            default: state_nxt = ST_PD;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= ST_PD;
            div_r <= '0;
            pend_r <= 1'b0;
            push_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            div_r <= (pd_req || tick) ? '0 : div_r + 1'b1;
            pend_r <= !pd_req && (tick || (pend_r && !step));
            push_r <= step;
        end
    end

    assign adc_take_o = step;

    // ************************************************************
    // Axis filters
    // ************************************************************
    afc_xyz_t lp1, lp2, hp, slope;
    wire clear = state_r == ST_PD;
    wire seed = state_r == ST_SEED;
    wire [3:0] shift = afc_shift(code);

    afc_axis #(.DW(DW)) u_ax_x (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .clear_i(clear),
        .step_i(step), .seed_i(seed), .shift_i(shift),
        .sample_i(adc_sample_i.x), .lp1_o(lp1.x), .lp2_o(lp2.x),
        .hp_o(hp.x), .slope_o(slope.x));
    afc_axis #(.DW(DW)) u_ax_y (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .clear_i(clear),
        .step_i(step), .seed_i(seed), .shift_i(shift),
        .sample_i(adc_sample_i.y), .lp1_o(lp1.y), .lp2_o(lp2.y),
        .hp_o(hp.y), .slope_o(slope.y));
    afc_axis #(.DW(DW)) u_ax_z (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .clear_i(clear),
        .step_i(step), .seed_i(seed), .shift_i(shift),
        .sample_i(adc_sample_i.z), .lp1_o(lp1.z), .lp2_o(lp2.z),
        .hp_o(hp.z), .slope_o(slope.z));

    // ************************************************************
    // Path selection and reference mode
    // ************************************************************
    afc_xyz_t ref_r;
    afc_xyz_t ref_out;
    afc_xyz_t sel_out;
    afc_sel_t out_sel;

    assign out_sel = !path ? (lp2_en ? SEL_LP2 : SEL_LP1) :
        (code == CUT_SLOPE ? SEL_SLOPE : SEL_HP);
    assign ref_out.x = lp1.x - ref_r.x;
    assign ref_out.y = lp1.y - ref_r.y;
    assign ref_out.z = lp1.z - ref_r.z;
    // Reference mode bypasses both the second stage and the high-pass
    assign sel_out = ref_cfg ? ref_out :
        out_sel == SEL_LP2 ? lp2 :
        out_sel == SEL_HP ? hp :
        out_sel == SEL_SLOPE ? slope : lp1;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ref_r <= '0;
            ref_held_r <= 1'b0;
            last_r <= '0;
            slope_o <= '0;
            orient_o <= '0;
        end else begin
            if (!ref_cfg) begin
                ref_held_r <= 1'b0;
            end else if (push_r && !ref_held_r) begin
                ref_r <= lp1;
                ref_held_r <= 1'b1;
            end
            if (push_r) begin
                last_r <= sel_out;
                slope_o <= slope;
                orient_o <= orient_sel ? lp2 : lp1;
            end
        end
    end

    // ************************************************************
    // Settling counter for software
    // ************************************************************
    // Reload wins over a sample that completes in the same cycle
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            settle_r <= '0;
        end else if (wr_filt) begin
            settle_r <= (reg_wdata_i[REF_BIT] && reg_wdata_i[PATH_BIT] &&
                reg_wdata_i[CUT_LSB +: 3] != CUT_SLOPE) ? 10'h001 :
                afc_discard(reg_wdata_i[PATH_BIT], lp2_en,
                reg_wdata_i[CUT_LSB +: 3]);
        end else if (wr_ctrl1) begin
            settle_r <= afc_discard(path, reg_wdata_i[LP2_EN_BIT], code);
        end else if (push_r && settle_r != '0) begin
            settle_r <= settle_r - 1'b1;
        end
    end

    // ************************************************************
    // Output FIFO
    // ************************************************************
    afc_fifo #(.W($bits(afc_xyz_t)), .DEPTH(FIFO_DEPTH_P)) u_fifo (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(push_r),
        .in_ready_o(fifo_ready),
        .in_data_i(sel_out),
        .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i),
        .out_data_o(out_data_o)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_take;
        step && adc_take_o;
    endsequence
    sequence s_push;
        push_r ##1 !push_r;
    endsequence

    step_push_a: assert property (
        s_take |=> s_push)
        else $error("sample step not followed by one push");
    pd_quiet_a: assert property (
        state_r == ST_PD |-> !step ##1 (lp1 == '0 && lp2 == '0))
        else $error("filters move or hold state in power-down");
    tick_space_a: assert property (
        tick |=> !tick [*2])
        else $error("sample ticks too close together");
    seed_exit_a: assert property (
        state_r == ST_RUN && !pd_req |=> state_r == ST_RUN)
        else $error("fast settle entered outside power-down exit");
    lp_path_a: assert property (
        push_r && !path && lp2_en && !ref_cfg |=>
        last_r == $past(lp2))
        else $error("second stage missing on low-pass path");
    slope_path_a: assert property (
        push_r && path && code == CUT_SLOPE |=> last_r == $past(slope))
        else $error("slope not routed on high-pass path");
    ref_latch_a: assert property (
        push_r && ref_cfg && !ref_held_r |=> ref_r == $past(lp1)
        ##1 ref_held_r)
        else $error("reference sample not latched");
    ref_hide_a: assert property (
        push_r && ref_cfg && ref_held_r |=> last_r.x ==
        $past(lp1.x) - $past(ref_r.x))
        else $error("reference output not lp1 minus stored sample");
    orient_feed_a: assert property (
        push_r && orient_sel |=> orient_o == $past(lp2))
        else $error("orientation not fed from second stage");
endmodule

// [core/afc_pkg.sv]
/*
 * Shared constants, types and helpers of the accelerometer filter chain.
 * Assumes a 25 MHz core clock and a 16-bit register port.
 */
package afc_pkg;

    // ************************************************************
    // Widths and timing
    // ************************************************************
    localparam int DW = 16;
    localparam int ADDR_W = 4;
    localparam int FIFO_DEPTH = 16;
    localparam int CLK_HZ = 25_000_000;
    localparam int ODR_MAX_HZ = 6667;
    // Cycles between samples at the top rate; lower rates shift this up
    localparam int BASE_DIV = CLK_HZ / ODR_MAX_HZ;
    localparam int DIV_W = 24;
    localparam int SETTLE_W = 10;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [ADDR_W-1:0] ADDR_CTRL1 = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_FILT = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_OUT_X = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_OUT_Y = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_OUT_Z = 4'h5;

    localparam int RATE_LSB = 4;
    localparam int LP2_EN_BIT = 1;
    localparam logic [DW-1:0] CTRL1_MASK = 16'h00F2;
    localparam logic [DW-1:0] CTRL1_RST = 16'h0000;

    localparam int CUT_LSB = 5;
    localparam int REF_BIT = 4;
    localparam int FAST_BIT = 3;
    localparam int PATH_BIT = 2;
    localparam int ORIENT_BIT = 0;
    localparam logic [DW-1:0] FILT_MASK = 16'h00FD;
    localparam logic [DW-1:0] FILT_RST = 16'h0000;

    localparam int ST_REF_BIT = 3;
    localparam int ST_SETTLING_BIT = 4;
    localparam int ST_CNT_LSB = 6;

    localparam logic [3:0] RATE_PD = 4'h0;
    localparam logic [3:0] RATE_MAX = 4'hA;
    localparam logic [2:0] CUT_SLOPE = 3'h0;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic signed [DW-1:0] z;
        logic signed [DW-1:0] y;
        logic signed [DW-1:0] x;
    } afc_xyz_t;

    typedef enum logic [2:0] {
        ST_PD = 3'b001,
        ST_SEED = 3'b010,
        ST_RUN = 3'b100
    } afc_state_t;

    typedef enum logic [3:0] {
        SEL_LP1 = 4'b0001,
        SEL_LP2 = 4'b0010,
        SEL_HP = 4'b0100,
        SEL_SLOPE = 4'b1000
    } afc_sel_t;

    // ************************************************************
    // Helpers
    // ************************************************************
    // IIR shift per cutoff code, OUTPUT_DATA_RATE/4 at code 0 down to OUTPUT_DATA_RATE/800 at 7
    function automatic logic [3:0] afc_shift(input logic [2:0] code);
        afc_shift = {1'b0, code} + 4'h1;
    endfunction

    // Worst-case samples to throw away after a filter change
    function automatic logic [SETTLE_W-1:0] afc_discard(
        input logic path, input logic lp2_en, input logic [2:0] code);
        logic [SETTLE_W-1:0] n;
        n = 10'h003;
        case (code)
            3'h1: n = path ? 10'h00E : 10'h00A;
            3'h2: n = 10'h013;
            3'h3: n = 10'h026;
            3'h4: n = 10'h04B;
            3'h5: n = 10'h096;
            3'h6: n = 10'h128;
            3'h7: n = 10'h253;
            default: n = 10'h003;
        endcase
        if (!path && !lp2_en) begin
            n = 10'h002;
        end
        afc_discard = n;
    endfunction

endpackage

// [core/afc_fifo.sv]
/*
 * Synchronous FIFO for filtered samples.
 * Assumes one clock; the writer only pushes while ready is high.
 */
`timescale 1ns/1ns
module afc_fifo #(
    parameter int W = 48,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] rptr_r;
    logic [CW-1:0] cnt_r;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    assign in_ready_o = cnt_r != CW'(DEPTH);
    assign out_valid_o = cnt_r != '0;
    assign out_data_o = mem_r[rptr_r];

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_r[wptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wptr_r <= bump(wptr_r);
            if (pop) rptr_r <= bump(rptr_r);
            cnt_r <= cnt_r + CW'(push) - CW'(pop);
        end
    end

    fifo_bound_a: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i) cnt_r <= CW'(DEPTH))
        else $error("fifo count beyond depth");
endmodule

// [core/afc_axis.sv]
/*
 * One axis of the filter chain: first low-pass, IIR low-pass,
 * high-pass and slope. Assumes step_i is a one-cycle pulse per sample.
 */
`timescale 1ns/1ns
module afc_axis #(
    parameter int DW = 16
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic clear_i,
    input wire logic step_i,
    input wire logic seed_i,
    input wire logic [3:0] shift_i,
    input wire logic signed [DW-1:0] sample_i,
    output logic signed [DW-1:0] lp1_o,
    output logic signed [DW-1:0] lp2_o,
    output logic signed [DW-1:0] hp_o,
    output logic signed [DW-1:0] slope_o
);
    logic signed [DW-1:0] x_prev_r;

    // Two-tap average puts a null at half the sample rate
    wire signed [DW:0] sum = {sample_i[DW-1], sample_i} +
        {x_prev_r[DW-1], x_prev_r};
    wire signed [DW-1:0] lp1_nxt = sum[DW:1];
    wire signed [DW:0] dlp = {lp1_nxt[DW-1], lp1_nxt} -
        {lp2_o[DW-1], lp2_o};
    wire signed [DW:0] dlp_sh = dlp >>> shift_i;
    wire signed [DW:0] lp2_sum = {lp2_o[DW-1], lp2_o} + dlp_sh;
    wire signed [DW-1:0] lp2_nxt = seed_i ? lp1_nxt : lp2_sum[DW-1:0];
    wire signed [DW:0] hp_d = {lp1_nxt[DW-1], lp1_nxt} -
        {lp2_nxt[DW-1], lp2_nxt};
    wire signed [DW:0] sl_d = {lp1_nxt[DW-1], lp1_nxt} -
        {lp1_o[DW-1], lp1_o};

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            x_prev_r <= '0;
            lp1_o <= '0;
            lp2_o <= '0;
            hp_o <= '0;
            slope_o <= '0;
        end else if (clear_i) begin
            x_prev_r <= '0;
            lp1_o <= '0;
            lp2_o <= '0;
            hp_o <= '0;
            slope_o <= '0;
        end else if (step_i) begin
            x_prev_r <= sample_i;
            lp1_o <= lp1_nxt;
            lp2_o <= lp2_nxt;
            // Wraps on full-scale steps; normal inputs stay in range
            hp_o <= hp_d[DW-1:0];
            slope_o <= sl_d[DW:1];
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    lp1_average_a: assert property (
        step_i && !clear_i |=> lp1_o ==
        DW'(((DW + 1)'($past(sample_i)) +
        (DW + 1)'($past(x_prev_r))) >>> 1))
        else $error("first stage is not the two-tap mean");
    slope_half_a: assert property (
        step_i && !clear_i |=> 2 * (DW + 1)'(slope_o) ==
        (DW + 1)'(lp1_o - $past(lp1_o)) ||
        2 * (DW + 1)'(slope_o) + 1 == (DW + 1)'(lp1_o - $past(lp1_o)))
        else $error("slope is not half the sample difference");
    seed_settle_a: assert property (
        step_i && seed_i && !clear_i |=> lp2_o == lp1_o && hp_o == '0)
        else $error("fast settle did not seed the filter");
endmodule

// [bench/afc_adc_model.sv]
/*
 * Behavioural converter that feeds three-axis samples to the chain.
 * Assumes the chain raises take_i for one cycle per sample it takes.
 */
`timescale 1ns/1ns
module afc_adc_model
    import afc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic take_i,
    output afc_pkg::afc_xyz_t sample_o
);
    logic [31:0] lfsr_r;

    function automatic logic [31:0] lfsr_nxt(input logic [31:0] v);
        lfsr_nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Multiples of 4 keep the half-sum and the halved slope exact
    function automatic logic [DW-1:0] scale(input logic [11:0] r);
        scale = {{4{r[11]}}, r[11:2], 2'b00};
    endfunction

    // ************************************************************
    // A new conversion is shown only once the old one was taken
    // ************************************************************
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lfsr_r <= 32'h53A462EB;
        end else if (take_i) begin
            lfsr_r <= lfsr_nxt(lfsr_r);
        end
    end
    assign sample_o = {scale(lfsr_r[31:20]), scale(lfsr_r[21:10]),
                       scale(lfsr_r[11:0])};
endmodule

// [bench/testbench.sv]
/*
 * Self-checking bench for the accelerometer filter chain.
 * Assumes the converter model of afc_adc_model.sv on the sample port.
 */
`timescale 1ns/1ns
module testbench;
    import afc_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DW-1:0] wdata = '0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic rd_d = 1'b0;
    logic oready = 1'b0;
    logic [DW-1:0] rdata;
    logic take;
    logic ovalid;
    afc_xyz_t smp;
    afc_xyz_t dout;
    logic [47:0] exp_q[$];
    bit ok_q[$];
    logic [31:0] rq[$];
    logic [31:0] rx;
    logic [47:0] ex;
    logic signed [DW-1:0] cur, l1;
    logic signed [DW-1:0] sp[3] = '{0, 0, 0};
    logic signed [DW-1:0] lp[3] = '{0, 0, 0};
    logic signed [DW-1:0] rv[3] = '{0, 0, 0};
    int err_count = 0;
    int checks = 0;
    int mode = 0;
    int skip = 0;
    int ntake = 0;
    bit ref_new = 1'b0;
    int disc[8] = '{3, 10, 19, 38, 75, 150, 296, 595};

    always #20 clk = ~clk;

    afc_chain #(.BASE_DIV_P(4), .FIFO_DEPTH_P(FIFO_DEPTH)) afc_chain_i (
        .ref_clk_i(clk), .resetn_i(resetn), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
        .reg_rdata_o(rdata), .adc_sample_i(smp), .adc_take_o(take),
        .out_valid_o(ovalid), .out_ready_i(oready), .out_data_o(dout),
        .slope_o(), .orient_o());

    afc_adc_model afc_adc_model_i (.ref_clk_i(clk), .resetn_i(resetn),
        .take_i(take), .sample_o(smp));

    task automatic check(input string nm, input logic [47:0] seen,
                         input logic [47:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ************************************************************
    // Expected words noted per take, compared as words leave
    // ************************************************************
    always @(posedge clk) begin
        if (resetn && take === 1'b1) begin
            ntake++;
            for (int i = 0; i < 3; i++) begin
                cur = smp[16*i +: 16];
                l1 = (cur + sp[i]) >>> 1;
                if (ref_new) begin
                    rv[i] = l1;
                end
                ex[16*i +: 16] = (mode == 1) ? (l1 - lp[i]) >>> 1 :
                                 (mode == 2) ? l1 - rv[i] : l1;
                sp[i] = cur;
                lp[i] = l1;
            end
            ref_new = 1'b0;
            exp_q.push_back(ex);
            ok_q.push_back(skip == 0);
            if (skip > 0) begin
                skip--;
            end
        end
    end

    always @(posedge clk) begin
        rd_d <= rd_s;
        if (rd_d) begin
            rx = rq.pop_front();
            check("read data", {32'h0, rdata & rx[31:16]}, {32'h0, rx[15:0]});
        end
        if (resetn && ovalid === 1'b1 && oready === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("spurious word", 48'h1, 48'h0);
            end else if (ok_q.pop_front()) begin
                check("out data", dout, exp_q.pop_front());
            end else begin
                void'(exp_q.pop_front());
            end
        end
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DW-1:0] m,
                      input logic [DW-1:0] e);
        rq.push_back({m, e});
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
    endtask

    // Power-down clears the filters, so the history restarts at zero
    task automatic set_path(input logic [DW-1:0] f, input int m, input int s);
        wr(ADDR_CTRL1, 16'h0000);
        sp = '{0, 0, 0};
        lp = '{0, 0, 0};
        wr(ADDR_FILT, f);
        mode = m;
        skip = s;
        ref_new = (m == 2);
        wr(ADDR_CTRL1, 16'h00A0);
    endtask

    task automatic drain;
        wr(ADDR_CTRL1, 16'h0000);
        oready <= 1'b1;
        for (int n = 0; n < 200 && exp_q.size() > 0; n++) begin
            @(posedge clk);
        end
        if (exp_q.size() > 0) begin
            err_count++;
            $display("MISMATCH drain expected 0 seen %0d", exp_q.size());
            complete_run();
        end
    endtask

    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rd(ADDR_STATUS, 16'hFFFF, 16'h0001);
        rd(4'hF, 16'hFFFF, 16'h0000);
        wr(ADDR_CTRL1, 16'hFF0F);
        rd(ADDR_CTRL1, 16'hFFFF, 16'h0002);
        wr(ADDR_FILT, 16'hFFFF);
        rd(ADDR_FILT, 16'hFFFF, FILT_MASK);
        wr(4'hF, 16'hFFFF);
        rd(4'hF, 16'hFFFF, 16'h0000);
        $display("register test done");
        for (int c = 1; c < 8; c++) begin
            for (int p = 0; p < 2; p++) begin
                wr(ADDR_FILT, {8'h00, c[2:0], 2'b00, p[0], 2'b00});
                rd(ADDR_STATUS, 16'hFFFF, {(p == 1 && c == 1) ? 10'h00E :
                   disc[c][9:0], 6'h11});
            end
        end
        wr(ADDR_CTRL1, 16'h0000);
        wr(ADDR_FILT, 16'h0000);
        rd(ADDR_STATUS, 16'hFFFF, {10'h002, 6'h11});
        $display("discard test done");
        ntake = 0;
        // Fast settle only seeds the second stage; the output stays lp1
        set_path(16'h0008, 0, 2);
        repeat (300) @(posedge clk);
        check("takes while full", 48'(ntake), 48'(FIFO_DEPTH));
        check("valid while full", {47'h0, ovalid}, 48'h1);
        drain();
        $display("low-pass test done");
        set_path(16'h0004, 1, 3);
        repeat (200) @(posedge clk);
        drain();
        $display("slope test done");
        set_path(16'h0035, 2, 3);
        repeat (200) @(posedge clk);
        rd(ADDR_STATUS, 16'h000F, 16'h000C);
        drain();
        $display("reference test done");
        complete_run();
    end
endmodule
